// >>> logic/timer_run_control.sv
// Run and control logic for one 16-bit up-counting timer channel: enable,
// run and control registers, prescaler gating and the up-counter.
// Assumes idleMode and syncRun come from logic on the same clock.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module timer_run_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire timer_run_pkg::reg_req_t req,
    output logic [31:0] rdata,
    // System status
    input wire logic idleMode,
    input wire logic syncRun,
    // Channel outputs
    output timer_run_pkg::timer_cfg_t cfg,
    output logic [15:0] upCount,
    output logic counting,
    output logic prescaleTick
);
    import timer_run_pkg::*;

    // Whole module state
    typedef struct packed {
        logic moduleEnable;
        logic countRun;
        logic prescalerRun;
        logic idleOperate;
        logic syncSelect;
        logic controlSpare;
        logic doubleBuffer;
        logic [COUNT_WIDTH-1:0] count;
        logic [COUNT_WIDTH-1:0] snapshot;
        logic [31:0] rdata;
    } run_state_t;

    run_state_t state_q;
    run_state_t state_d;

    logic tick;
    logic idleHold;
    logic prescEnable;
    logic countEnable;
    logic gatedAccess;
    logic wrEnable;
    logic wrRun;
    logic wrControl;
    logic [31:0] readWord;

    // Address match, shared by reads and writes
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction : hit

    // Idle low-power stop unless idle operation is allowed
    assign idleHold = idleMode && !state_q.idleOperate;

    // Prescaler runs only with its run bit and the module clock on
    assign prescEnable = state_q.moduleEnable && state_q.prescalerRun && !idleHold;

    // Counter advances when running, in step with the master if synchronous
    assign countEnable = state_q.moduleEnable && state_q.countRun && !idleHold
        && (!state_q.syncSelect || syncRun);

    // Registers other than enable are reachable only while enabled
    assign gatedAccess = state_q.moduleEnable;

    // Write decode
    assign wrEnable = req.wr && hit(req.addr, ADDR_ENABLE);
    assign wrRun = req.wr && gatedAccess && hit(req.addr, ADDR_RUN);
    assign wrControl = req.wr && gatedAccess && hit(req.addr, ADDR_CONTROL);

    timer_prescaler u_prescaler (
        .clk(clk),
        .rst(rst),
        .enable(prescEnable),
        .tick(tick)
    );

    // Read word selection; unused bits read zero
    always_comb begin
        readWord = WORD_RESET;
        if (hit(req.addr, ADDR_ENABLE)) begin
            readWord[BIT_MODULE_ENABLE] = state_q.moduleEnable;
        end else if (gatedAccess) begin
            if (hit(req.addr, ADDR_RUN)) begin
                readWord[BIT_COUNT_RUN] = state_q.countRun;
                readWord[BIT_PRESCALER_RUN] = state_q.prescalerRun;
            end else if (hit(req.addr, ADDR_CONTROL)) begin
                readWord[BIT_IDLE_OPERATE] = state_q.idleOperate;
                readWord[BIT_SYNC_SELECT] = state_q.syncSelect;
                readWord[BIT_CONTROL_SPARE] = state_q.controlSpare;
                readWord[BIT_DOUBLE_BUFFER] = state_q.doubleBuffer;
            end else if (hit(req.addr, ADDR_UPCOUNT)) begin
                // Live count while running, captured value while stopped
                readWord[COUNT_WIDTH-1:0] = state_q.countRun
                    ? state_q.count : state_q.snapshot;
            end
        end
    end

    // Next state
    always_comb begin
        state_d = state_q;
        // Read data stand for one cycle only
        state_d.rdata = req.rd ? readWord : WORD_RESET;
        if (wrEnable) begin
            state_d.moduleEnable = req.wdata[BIT_MODULE_ENABLE];
        end
        if (wrControl) begin
            state_d.doubleBuffer = req.wdata[BIT_DOUBLE_BUFFER];
            state_d.controlSpare = req.wdata[BIT_CONTROL_SPARE];
            state_d.syncSelect = req.wdata[BIT_SYNC_SELECT];
            state_d.idleOperate = req.wdata[BIT_IDLE_OPERATE];
        end
        // Capture the count every cycle it runs, for reads after a stop
        if (state_q.countRun && state_q.moduleEnable) begin
            state_d.snapshot = state_q.count;
        end
        // Count on each prescaler tick
        if (countEnable && tick) begin
            state_d.count = state_q.count + 16'h0001;
        end
        if (wrRun) begin
            state_d.prescalerRun = req.wdata[BIT_PRESCALER_RUN];
            state_d.countRun = req.wdata[BIT_COUNT_RUN];
            if (!req.wdata[BIT_COUNT_RUN]) begin
                // Stop and clear
                state_d.count = COUNT_RESET;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs from the state registers; counting also decodes idleMode and syncRun
    assign rdata = state_q.rdata;
    assign upCount = state_q.count;
    assign counting = countEnable;
    assign prescaleTick = tick;
    assign cfg.doubleBuffer = state_q.doubleBuffer;
    assign cfg.syncSelect = state_q.syncSelect;
    assign cfg.idleOperate = state_q.idleOperate;

    // Checks on the register and counter behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Stop write clears the counter
    AST_STOP_CLEARS: assert property (
        (req.wr && state_q.moduleEnable && req.addr == ADDR_RUN
            && !req.wdata[BIT_COUNT_RUN]) |=> (upCount == COUNT_RESET)
    ) else $error("counter not cleared by stop write");

    // A tick while counting adds exactly one
    AST_COUNT_STEP: assert property (
        (countEnable && tick && !req.wr) |=> (upCount == $past(upCount) + 16'h0001)
    ) else $error("counter did not advance by one");

    // No prescaler tick follows a disabled prescaler
    AST_PRESC_OFF: assert property (
        (!state_q.prescalerRun) |=> !prescaleTick
    ) else $error("prescaler ticked while stopped");

    // Reading a stopped counter returns the capture
    AST_STOPPED_READ: assert property (
        (req.rd && req.addr == ADDR_UPCOUNT && state_q.moduleEnable && !state_q.countRun)
            |=> (rdata[15:0] == $past(state_q.snapshot))
    ) else $error("stopped read not the captured count");

    // Double buffer bit follows a control write
    AST_DBUF_WRITE: assert property (
        (req.wr && state_q.moduleEnable && req.addr == ADDR_CONTROL)
            |=> (cfg.doubleBuffer == $past(req.wdata[BIT_DOUBLE_BUFFER]))
    ) else $error("double buffer bit not updated");

    // Synchronous channel holds without the master run
    AST_SYNC_HOLD: assert property (
        (state_q.syncSelect && !syncRun && !req.wr) |=> $stable(upCount)
    ) else $error("synchronous channel counted alone");

    // After two cycles of idle stop the counter holds on the next cycle
    AST_IDLE_HOLD: assert property (
        (idleMode && !cfg.idleOperate && !req.wr)[*2] |=> $stable(upCount)
    ) else $error("counter ran in idle stop");

    // Gated registers read zero and ignore writes
    AST_GATED_READ: assert property (
        (!state_q.moduleEnable && req.rd && req.addr != ADDR_ENABLE) |=> (rdata == WORD_RESET)
    ) else $error("gated register readable");

    AST_GATED_WRITE: assert property (
        (!state_q.moduleEnable && req.wr && req.addr == ADDR_CONTROL) |=> $stable(cfg)
    ) else $error("gated register written");

    // Unused run register bits read zero
    AST_RUN_RESERVED: assert property (
        (req.rd && req.addr == ADDR_RUN) |=> (rdata[31:3] == 29'h0 && rdata[1] == 1'b0)
    ) else $error("reserved run bits not zero");

    // A run write sets both run bits as written
    AST_RUN_WRITE: assert property (
        (req.wr && state_q.moduleEnable && req.addr == ADDR_RUN)
            |=> (state_q.countRun == $past(req.wdata[BIT_COUNT_RUN]))
    ) else $error("count run bit not updated");

    AST_PRUN_WRITE: assert property (
        (req.wr && state_q.moduleEnable && req.addr == ADDR_RUN)
            |=> (state_q.prescalerRun == $past(req.wdata[BIT_PRESCALER_RUN]))
    ) else $error("prescaler run bit not updated");

    // Counter holds whenever it is not enabled
    AST_STOPPED_HOLD: assert property (
        (!counting && !req.wr) |=> $stable(upCount)
    ) else $error("counter moved while not enabled");

    // Counter never moves without a prescaler tick
    AST_TICK_NEEDED: assert property (
        (!prescaleTick && !req.wr) |=> $stable(upCount)
    ) else $error("counter moved without a tick");

    // A running prescaler ticks every other cycle
    AST_PRESC_ON: assert property (
        (prescEnable [*2]) |=> (prescaleTick || $past(prescaleTick))
    ) else $error("prescaler failed to tick");

    // Running read returns the live count
    AST_RUNNING_READ: assert property (
        (req.rd && req.addr == ADDR_UPCOUNT && state_q.moduleEnable && state_q.countRun)
            |=> (rdata[15:0] == $past(upCount))
    ) else $error("running read not the live count");

    // Capture follows the count while running
    AST_CAPTURE: assert property (
        (state_q.countRun && state_q.moduleEnable) |=> (state_q.snapshot == $past(upCount))
    ) else $error("capture lagging the count");

    // Capture holds while stopped
    AST_CAPTURE_HOLD: assert property (
        (!state_q.countRun) |=> $stable(state_q.snapshot)
    ) else $error("capture changed while stopped");

    // Mode and idle bits follow a control write
    AST_SYNC_WRITE: assert property (
        (req.wr && state_q.moduleEnable && req.addr == ADDR_CONTROL)
            |=> (cfg.syncSelect == $past(req.wdata[BIT_SYNC_SELECT]))
    ) else $error("sync select bit not updated");

    AST_IDLE_WRITE: assert property (
        (req.wr && state_q.moduleEnable && req.addr == ADDR_CONTROL)
            |=> (cfg.idleOperate == $past(req.wdata[BIT_IDLE_OPERATE]))
    ) else $error("idle operate bit not updated");

    // Independent channel ignores the master run
    AST_INDEPENDENT: assert property (
        (state_q.moduleEnable && state_q.countRun && !state_q.syncSelect
            && !idleMode) |-> counting
    ) else $error("independent channel not counting");

    // Idle stop also halts the prescaler
    AST_IDLE_PRESC: assert property (
        (idleMode && !cfg.idleOperate) |=> !prescaleTick
    ) else $error("prescaler ran in idle stop");

    // Idle operation keeps the counter enabled
    AST_IDLE_RUN: assert property (
        (idleMode && cfg.idleOperate && state_q.moduleEnable && state_q.countRun
            && !cfg.syncSelect) |-> counting
    ) else $error("idle operation stopped the counter");

    // Enable register always writable
    AST_ENABLE_WRITE: assert property (
        (req.wr && req.addr == ADDR_ENABLE)
            |=> (state_q.moduleEnable == $past(req.wdata[BIT_MODULE_ENABLE]))
    ) else $error("enable bit not updated");

    AST_GATED_RUN: assert property (
        (!state_q.moduleEnable && req.wr && req.addr == ADDR_RUN)
            |=> ($stable(state_q.countRun) && $stable(state_q.prescalerRun))
    ) else $error("gated run register written");

    // Nothing runs with the module clock off
    AST_GATED_STOP: assert property (
        (!state_q.moduleEnable) |-> (!counting && !prescEnable)
    ) else $error("timer active while disabled");

    // Unused control, counter and enable bits read zero
    AST_CTRL_RESERVED: assert property (
        (req.rd && req.addr == ADDR_CONTROL)
            |=> (rdata[31:8] == 24'h0 && rdata[4] == 1'b0 && rdata[2:0] == 3'h0)
    ) else $error("reserved control bits not zero");

    AST_COUNT_RESERVED: assert property (
        (req.rd && req.addr == ADDR_UPCOUNT) |=> (rdata[31:16] == 16'h0)
    ) else $error("reserved counter bits not zero");

    AST_ENABLE_RESERVED: assert property (
        (req.rd && req.addr == ADDR_ENABLE) |=> (rdata[31:1] == 31'h0)
    ) else $error("reserved enable bits not zero");

    // Main scenarios
    COV_COUNT: cover property (countEnable && tick ##1 upCount != COUNT_RESET);
    COV_STOP_READ: cover property (
        wrRun && !req.wdata[BIT_COUNT_RUN] ##[1:4] (req.rd && req.addr == ADDR_UPCOUNT)
    );
    COV_SYNC: cover property (state_q.syncSelect && syncRun && countEnable && tick);
    COV_IDLE_RUN: cover property (idleMode && cfg.idleOperate && countEnable && tick);

endmodule : timer_run_control
`default_nettype wire

// >>> logic/timer_run_pkg.sv
// Package for the timer run and control block: offsets, bit positions,
// reset values, counts and the carrier structs.
// Assumes a byte-addressed register port with one 32-bit word per register.
`default_nettype none
package timer_run_pkg;

    // Register byte offsets within the channel
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_RUN = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_UPCOUNT = 8'h1c;

    // Field positions
    localparam int BIT_MODULE_ENABLE = 0;
    localparam int BIT_COUNT_RUN = 0;
    localparam int BIT_PRESCALER_RUN = 2;
    localparam int BIT_IDLE_OPERATE = 3;
    localparam int BIT_SYNC_SELECT = 5;
    localparam int BIT_CONTROL_SPARE = 6;
    localparam int BIT_DOUBLE_BUFFER = 7;

    // Widths and counts
    localparam int COUNT_WIDTH = 16;
    localparam int PRESCALE_WIDTH = 4;
    localparam logic [3:0] PRESCALE_LAST = 4'h1;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Register port request from the processor side
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Configuration presented to the compare and channel logic
    typedef struct packed {
        logic doubleBuffer;
        logic syncSelect;
        logic idleOperate;
    } timer_cfg_t;

endpackage : timer_run_pkg
`default_nettype wire

// >>> logic/timer_prescaler.sv
// Prescaler for one timer channel: a free divider that pulses tick once
// per PRESCALE_LAST+1 clocks while enabled, and clears when disabled.
// Assumes enable comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic enable,
    // Tick out
    output logic tick
);
    import timer_run_pkg::*;

    typedef struct packed {
        logic [PRESCALE_WIDTH-1:0] div;
        logic tick;
    } presc_state_t;

    presc_state_t state_q;
    presc_state_t state_d;

    // Divider next state; held at zero while stopped
    always_comb begin
        state_d = state_q;
        state_d.tick = 1'b0;
        if (!enable) begin
            state_d.div = '0;
        end else if (state_q.div == PRESCALE_LAST) begin
            state_d.div = '0;
            state_d.tick = 1'b1;
        end else begin
            state_d.div = state_q.div + 4'h1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign tick = state_q.tick;

endmodule : timer_prescaler
`default_nettype wire

// >>> test/tb_top.sv
// Testbench for the timer run and control block: bus tasks, a reference
// model of the registers and counter, and a per-cycle output monitor.
// Assumes the design prescaler ticks every other clock while enabled.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import timer_run_pkg::*;
    logic clk, rst, idleMode, syncRun, counting, prescaleTick;
    reg_req_t req;
    logic [31:0] rdata, seed, rv;
    logic [15:0] upCount;
    timer_cfg_t cfg;
    logic [7:0] addrs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h40};
    int n_fail, total_checks, nTick;
    int en, run, prun, ctl, cnt, snap, pdiv, ptick;

    timer_run_control timer_run_control_inst (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .idleMode(idleMode),
        .syncRun(syncRun), .cfg(cfg), .upCount(upCount), .counting(counting),
        .prescaleTick(prescaleTick));

    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Random source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Counter enable as the model sees it
    function automatic bit runOn();
        return en && run && !(idleMode && !ctl[3]) && (!ctl[5] || syncRun);
    endfunction : runOn

    // Result comparisons
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t read got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t output got %h exp %h", $time, got, exp);
        end
    endtask : chk_out

    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input int exp);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        chk_reg(rdata, 32'(exp));
        @(negedge clk);
        chk_reg(rdata, 32'h0000_0000);
    endtask : rdchk

    // Ticks seen over a 20-cycle window
    task automatic ticks(input int exp);
        @(posedge clk);
        nTick = 0;
        repeat (20) @(posedge clk);
        chk_out(32'(nTick), 32'(exp));
    endtask : ticks

    // Reference model, fed with pre-edge values
    always @(posedge clk) begin
        if (rst) begin
            en = 0;
            run = 0;
            prun = 0;
            ctl = 0;
            cnt = 0;
            snap = 0;
            pdiv = 0;
            ptick = 0;
        end else begin
            if (en && run) snap = cnt;
            if (runOn() && ptick) cnt = (cnt + 1) % 65536;
            // Prescaler: one tick per PRESCALE_LAST+1 enabled clocks
            if (!(en && prun && !(idleMode && !ctl[3]))) begin
                pdiv = 0;
                ptick = 0;
            end else begin
                ptick = (pdiv == PRESCALE_LAST);
                pdiv = ptick ? 0 : pdiv + 1;
            end
            if (req.wr && req.addr == ADDR_ENABLE) en = req.wdata[0];
            else if (req.wr && en && req.addr == ADDR_RUN) begin
                run = req.wdata[0];
                prun = req.wdata[2];
                if (!run) cnt = 0;
            end else if (req.wr && en && req.addr == ADDR_CONTROL) ctl = req.wdata & 32'he8;
        end
    end

    // Per-cycle comparison of the channel outputs
    always @(negedge clk) begin
        if (!rst) begin
            chk_out(32'(counting), 32'(runOn()));
            chk_out(32'(upCount), 32'(cnt));
            chk_out(32'(cfg), 32'({ctl[7], ctl[5], ctl[3]}));
            chk_out(32'(prescaleTick), 32'(ptick));
            if (prescaleTick === 1'b1) nTick++;
        end
    end

    // Verdict
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Watchdog far beyond the expected run of under 1000 cycles
    initial begin
        #(5000 * 20);
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        seed = 32'h79f0;
        rst = 1'b1;
        idleMode = 1'b0;
        syncRun = 1'b0;
        req = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped places
        foreach (addrs[i]) rdchk(addrs[i], 0);
        // Writes refused while the block is disabled
        wr(ADDR_RUN, 32'h5);
        wr(ADDR_CONTROL, 32'ha8);
        rdchk(ADDR_RUN, 0);
        rdchk(ADDR_CONTROL, 0);
        wr(ADDR_ENABLE, 32'h1);
        rdchk(ADDR_ENABLE, 1);
        rdchk(ADDR_RUN, 0);
        // Random legal control values
        repeat (8) begin
            rv = xs() & 32'ha8;
            wr(ADDR_CONTROL, rv);
            rdchk(ADDR_CONTROL, rv);
        end
        // Prescaler on its own, then off
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_RUN, 32'h4);
        rdchk(ADDR_RUN, 4);
        ticks(10);
        wr(ADDR_RUN, 32'h0);
        repeat (2) @(posedge clk);
        ticks(0);
        // Counting under every idle and sync setting
        wr(ADDR_RUN, 32'h5);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CONTROL, (m[0] ? 32'h08 : 32'h0) | (m[1] ? 32'h20 : 32'h0));
            repeat (30) begin
                @(posedge clk);
                rv = xs();
                idleMode <= rv[0] & rv[1];
                syncRun <= rv[2] | rv[3];
            end
        end
        idleMode <= 1'b0;
        // Stopped counter reads its last running value
        wr(ADDR_RUN, 32'h0);
        // Let the model take its capture before it is read
        @(negedge clk);
        rdchk(ADDR_UPCOUNT, snap);
        // Settings kept across a disable
        wr(ADDR_CONTROL, 32'ha8);
        wr(ADDR_ENABLE, 32'h0);
        rdchk(ADDR_CONTROL, 0);
        wr(ADDR_ENABLE, 32'h1);
        rdchk(ADDR_CONTROL, 32'ha8);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
